// file: logic/uft_defines.vh
/*
  shared constants for the serial port transmitter: format reset values,
  parity encodings, field widths and timing.
  assumes inclusion by bare name from the logic files.
*/
`ifndef UFT_DEFINES_VH
`define UFT_DEFINES_VH

// power-on format: 8 data bits, no parity, one stop bit
`define UFT_RST_DATA_LEN 1'b0
`define UFT_RST_PARITY_ON 1'b0
`define UFT_RST_STOP_CNT 1'b0
`define UFT_RST_PTYPE 2'h0
`define UFT_RST_DIVISOR 16'h0010
`define UFT_RST_FRAC 3'h0

// parity type encodings
`define UFT_PAR_ODD 2'h0
`define UFT_PAR_EVEN 2'h1
`define UFT_PAR_MARK 2'h2
`define UFT_PAR_SPACE 2'h3

// widths
`define UFT_DIV_W 16
`define UFT_FRAC_W 3
`define UFT_WORD_W 9

// clock and pin filter
`define UFT_CLK_PERIOD_NS 5
`define UFT_SYNC_STAGES 3

`endif

// file: logic/uft_skid_buf.v
/*
  two-entry buffer with valid and ready on both sides.
  assumes a single clock and that the source honours in_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module uft_skid_buf #(
  parameter W = 9
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // flush, empties both entries
  input wire flush,
  // filling side
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_ff [0:1];
  reg rd_ptr_ff;
  reg wr_ptr_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;

  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and occupancy bookkeeping
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (flush) begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push)
        wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      if (push && !pop)
        cnt_ff <= cnt_ff + 2'h1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end

  // storage, no reset needed
  always @(posedge clk) begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end
endmodule // uft_skid_buf
`default_nettype wire

// file: logic/uft_baud_gen.v
/*
  free-running bit timer with fractional adjust.
  assumes divisor is at least 2 and is changed only while idle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uft_defines.vh"
module uft_baud_gen #(
  parameter DW = `UFT_DIV_W
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // restart at frame start
  input wire restart,
  // setting
  input wire [DW-1:0] divisor,
  input wire [`UFT_FRAC_W-1:0] frac_adjust,
  // one pulse per bit period end
  output reg bit_tick_ff
);
  reg [DW-1:0] cnt_ff;
  reg [`UFT_FRAC_W:0] acc_ff;
  reg extra_ff;
  wire [`UFT_FRAC_W:0] acc_sum;
  wire [DW-1:0] last;

  assign acc_sum = {1'b0, acc_ff[`UFT_FRAC_W-1:0]} + {1'b0, frac_adjust};
  // one extra clock when the sum carries into bit 3
  assign last = extra_ff ? divisor : divisor - {{(DW-1){1'b0}}, 1'b1};

  // period counter and fraction accumulator
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= {DW{1'b0}};
      acc_ff <= {(`UFT_FRAC_W+1){1'b0}};
      extra_ff <= 1'b0;
      bit_tick_ff <= 1'b0;
    end else if (restart) begin
      // restart cycle counts as the first clock of the start bit
      cnt_ff <= {{(DW-1){1'b0}}, 1'b1};
      acc_ff <= {1'b0, frac_adjust};
      extra_ff <= 1'b0; // start bit never carries
      bit_tick_ff <= 1'b0;
    end else if (cnt_ff >= last) begin
      cnt_ff <= {DW{1'b0}};
      acc_ff <= acc_sum;
      extra_ff <= acc_sum[`UFT_FRAC_W];
      bit_tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + {{(DW-1){1'b0}}, 1'b1};
      bit_tick_ff <= 1'b0;
    end
  end
endmodule // uft_baud_gen
`default_nettype wire

// file: logic/uft_tx_top.v
/*
  serial port format control and transmit path: buffer, shifter, flags.
  assumes software drives control levels and one-cycle access strobes on
  the system clock; the receive pin only passes a pin filter here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uft_defines.vh"

// What this block does
// - frames are NRZ: start, data, optional parity, then stop bits.
// - data_len_sel picks 8 or 9 bits; ninth comes from tx_bit9.
// - parity_on enables parity; parity_type_sel picks odd, even, mark, space.
// - stop_count_sel sends one or two stop bits.
// - reset format is eight bits, no parity, one stop bit.
// - bits go least significant first; both directions share format, rate.
// - bit timing comes from a free-running 16-bit divider.
// - with port, tx, rx on, pins serve the port; line idles high.
// - port off releases pins and empties the buffer.
// - port off clears enables and error flags, sets idle and empty flags.
// - port off aborts activity at once; re-enable keeps the settings.
// - shifter loads only after previous stop bit has gone out.
// - frame starts once tx on, data written and bit timing running.
// - clearing tx_on mid-frame stops and resets the transmitter.
// - write when idle goes straight to shifter, empty flag stays set.
// - writes are refused while the empty flag is low.
// - status read then data write clears idle flag, and empty flag unless the word goes straight to an idle shifter.
// - empty flag with tx_irq_on and port on raises the interrupt request.
// - idle flag sets when a frame completes after its stop bits with no word waiting.
// - bit period is divisor plus fraction over eight via accumulator.
module uft_tx_top #(
  parameter DW = `UFT_DIV_W,
  parameter WW = `UFT_WORD_W
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // enables
  input wire port_on,
  input wire tx_on,
  input wire rx_on,
  input wire tx_irq_on,
  input wire break_request,
  // frame format
  input wire data_len_sel,
  input wire parity_on,
  input wire [1:0] parity_type_sel,
  input wire stop_count_sel,
  input wire tx_bit9,
  // bit timing
  input wire [DW-1:0] divisor,
  input wire [`UFT_FRAC_W-1:0] frac_adjust,
  // software access strobes
  input wire status_rd,
  input wire data_wr,
  input wire [7:0] data_buffer,
  // status
  output reg tx_empty_flag_ff,
  output reg tx_idle_flag_ff,
  output reg rx_idle_flag_ff,
  output reg tx_irq_ff,
  output reg tx_on_eff_ff,
  output reg rx_on_eff_ff,
  output reg break_eff_ff,
  output reg rx_avail_flag_ff,
  output reg overrun_flag_ff,
  output reg framing_flag_ff,
  output reg parity_fault_flag_ff,
  output reg noise_flag_ff,
  // pins
  input wire serial_in_pin,
  output reg serial_out_pin_ff,
  output reg serial_out_oe_ff,
  output reg serial_in_sel_ff,
  output reg serial_in_lvl_ff
);
  // one-hot transmitter states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_DATA = 5'h04;
  localparam [4:0] S_PAR = 5'h08;
  localparam [4:0] S_STOP = 5'h10;

  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [WW-1:0] tx_shifter_ff;
  reg [WW-1:0] nxt_shifter;
  reg [3:0] bit_cnt_ff;
  reg [3:0] nxt_bit_cnt;
  reg stop_cnt_ff;
  reg nxt_stop_cnt;
  reg par_bit_ff;
  reg nxt_par_bit;
  reg line;
  reg frame_done;
  reg load_now;
  reg armed_ff;
  reg [`UFT_SYNC_STAGES-1:0] rx_sync_ff;

  wire enabled;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [WW-1:0] buf_out_data;
  wire wr_ok;
  wire flush;
  wire bit_tick;
  wire [WW-1:0] wr_word;
  wire idle_now;

  // transmitter runs only with port and tx enabled
  assign enabled = port_on && tx_on_eff_ff;
  assign flush = !port_on;
  assign idle_now = (state_ff == S_IDLE);
  // ninth bit joins the byte in 9-bit mode
  assign wr_word = {data_len_sel & tx_bit9, data_buffer};
  // writes are refused while the empty flag is low
  assign wr_ok = data_wr && tx_empty_flag_ff && buf_in_ready;

  // parity over the word's used bits
  function calc_parity;
    input [WW-1:0] word;
    input len9;
    input [1:0] ptype;
    reg ones;
    begin
      ones = ^word[7:0] ^ (len9 & word[8]);
      case (ptype)
        `UFT_PAR_ODD: calc_parity = ~ones;
        `UFT_PAR_EVEN: calc_parity = ones;
        `UFT_PAR_MARK: calc_parity = 1'b1;
        default: calc_parity = 1'b0;
      endcase
    end
  endfunction

  // data buffer between software and the shifter
  uft_skid_buf #(
    .W(WW)
  ) u_buf (
    .clk(clk),
    .arst_n(arst_n),
    .flush(flush),
    .in_valid(wr_ok),
    .in_data(wr_word),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_ready(load_now),
    .out_data(buf_out_data)
  );

  // bit timer, restarted when a frame begins from idle
  uft_baud_gen #(
    .DW(DW)
  ) u_baud (
    .clk(clk),
    .arst_n(arst_n),
    .restart(load_now && idle_now),
    .divisor(divisor),
    .frac_adjust(frac_adjust),
    .bit_tick_ff(bit_tick)
  );

  // transmitter sequencing
  always @* begin
    nxt_state = state_ff;
    nxt_shifter = tx_shifter_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_stop_cnt = stop_cnt_ff;
    nxt_par_bit = par_bit_ff;
    line = 1'b1;
    frame_done = 1'b0;
    load_now = 1'b0;
    case (state_ff)
      S_IDLE: begin
        // idle: a waiting word starts at once
        if (enabled && buf_out_valid) begin
          load_now = 1'b1;
          nxt_shifter = buf_out_data;
          nxt_par_bit = calc_parity(buf_out_data, data_len_sel,
                                    parity_type_sel);
          nxt_bit_cnt = 4'h0;
          nxt_state = S_START;
        end
      end
      S_START: begin
        line = 1'b0;
        if (bit_tick)
          nxt_state = S_DATA;
      end
      S_DATA: begin
        line = tx_shifter_ff[0];
        if (bit_tick) begin
          nxt_shifter = {1'b0, tx_shifter_ff[WW-1:1]};
          nxt_bit_cnt = bit_cnt_ff + 4'h1;
          if (bit_cnt_ff == (data_len_sel ? 4'h8 : 4'h7))
            nxt_state = parity_on ? S_PAR : S_STOP;
          nxt_stop_cnt = stop_count_sel;
        end
      end
      S_PAR: begin
        line = par_bit_ff;
        if (bit_tick)
          nxt_state = S_STOP;
      end
      S_STOP: begin
        line = 1'b1;
        if (bit_tick) begin
          if (stop_cnt_ff) begin
            nxt_stop_cnt = 1'b0;
          end else begin
            frame_done = 1'b1;
            // next word only after the stop bit has gone out
            if (buf_out_valid) begin
              load_now = 1'b1;
              nxt_shifter = buf_out_data;
              nxt_par_bit = calc_parity(buf_out_data, data_len_sel,
                                        parity_type_sel);
              nxt_bit_cnt = 4'h0;
              nxt_state = S_START;
            end else begin
              nxt_state = S_IDLE;
            end
          end
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // state registers, aborted by disable
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= S_IDLE;
      tx_shifter_ff <= {WW{1'b0}};
      bit_cnt_ff <= 4'h0;
      stop_cnt_ff <= 1'b0;
      par_bit_ff <= 1'b0;
    end else if (!enabled) begin
      state_ff <= S_IDLE;
      bit_cnt_ff <= 4'h0;
      stop_cnt_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tx_shifter_ff <= nxt_shifter;
      bit_cnt_ff <= nxt_bit_cnt;
      stop_cnt_ff <= nxt_stop_cnt;
      par_bit_ff <= nxt_par_bit;
    end
  end

  // effective enables: port off clears them; with port on they follow the controls
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_on_eff_ff <= 1'b0;
      rx_on_eff_ff <= 1'b0;
      break_eff_ff <= 1'b0;
    end else if (!port_on) begin
      tx_on_eff_ff <= 1'b0;
      rx_on_eff_ff <= 1'b0;
      break_eff_ff <= 1'b0;
    end else begin
      tx_on_eff_ff <= tx_on;
      rx_on_eff_ff <= rx_on;
      break_eff_ff <= break_request;
    end
  end

  // status read arms the clear; the following data write completes it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      armed_ff <= 1'b0;
    else if (status_rd)
      armed_ff <= 1'b1;
    else if (data_wr)
      armed_ff <= 1'b0;
  end

  // empty and idle flags, hardware set wins over software clear
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_empty_flag_ff <= 1'b1;
      tx_idle_flag_ff <= 1'b1;
    end else if (!port_on) begin
      tx_empty_flag_ff <= 1'b1;
      tx_idle_flag_ff <= 1'b1;
    end else begin
      if (wr_ok && idle_now && enabled && !buf_out_valid)
        tx_empty_flag_ff <= 1'b1;
      else if (load_now)
        tx_empty_flag_ff <= 1'b1;
      else if (wr_ok && armed_ff)
        tx_empty_flag_ff <= 1'b0;
      else if (buf_in_ready && !buf_out_valid)
        tx_empty_flag_ff <= 1'b1;
      if (frame_done && !buf_out_valid)
        tx_idle_flag_ff <= 1'b1;
      else if (!enabled && !idle_now)
        tx_idle_flag_ff <= 1'b1;
      else if (wr_ok && armed_ff)
        tx_idle_flag_ff <= 1'b0;
    end
  end

  // receive side flags held at their disabled values
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_idle_flag_ff <= 1'b1;
      rx_avail_flag_ff <= 1'b0;
      overrun_flag_ff <= 1'b0;
      framing_flag_ff <= 1'b0;
      parity_fault_flag_ff <= 1'b0;
      noise_flag_ff <= 1'b0;
    end else begin
      rx_idle_flag_ff <= 1'b1;
      rx_avail_flag_ff <= 1'b0;
      overrun_flag_ff <= 1'b0;
      framing_flag_ff <= 1'b0;
      parity_fault_flag_ff <= 1'b0;
      noise_flag_ff <= 1'b0;
    end
  end

  // interrupt request from the empty flag
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      tx_irq_ff <= 1'b0;
    else
      tx_irq_ff <= tx_irq_on && tx_empty_flag_ff && port_on;
  end

  // pin drive: line idles high, released when disabled
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out_pin_ff <= 1'b1;
      serial_out_oe_ff <= 1'b0;
      serial_in_sel_ff <= 1'b0;
    end else begin
      serial_out_pin_ff <= enabled ? line : 1'b1;
      serial_out_oe_ff <= enabled;
      serial_in_sel_ff <= port_on && rx_on_eff_ff;
    end
  end

  // receive pin filter: change taken once stages two and three agree
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sync_ff <= {`UFT_SYNC_STAGES{1'b1}};
      serial_in_lvl_ff <= 1'b1;
    end else begin
      rx_sync_ff <= {rx_sync_ff[`UFT_SYNC_STAGES-2:0], serial_in_pin};
      if (rx_sync_ff[1] == rx_sync_ff[2])
        serial_in_lvl_ff <= rx_sync_ff[2];
    end
  end
endmodule // uft_tx_top
`default_nettype wire

// file: verification/uft_checker.sv
/*
  concurrent checks on the transmitter top: pins, flags, interrupt.
  assumes one clock domain; bound onto uft_tx_top at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module uft_checker (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // controls and strobes
  input wire logic port_on,
  input wire logic tx_on,
  input wire logic tx_irq_on,
  input wire logic status_rd,
  input wire logic data_wr,
  // status
  input wire logic tx_empty_flag_ff,
  input wire logic tx_idle_flag_ff,
  input wire logic rx_idle_flag_ff,
  input wire logic tx_irq_ff,
  input wire logic tx_on_eff_ff,
  input wire logic rx_on_eff_ff,
  input wire logic break_eff_ff,
  // pins
  input wire logic serial_out_pin_ff,
  input wire logic serial_out_oe_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // port held off, and status access then data write
  sequence s_port_off;
    !port_on ##1 !port_on;
  endsequence
  sequence s_rd_wr;
    status_rd ##1 (data_wr && port_on && tx_on && tx_on_eff_ff);
  endsequence
  AST_PORT_OFF_PIN: assert property (s_port_off |-> !serial_out_oe_ff)
    else $error("pin driven with port off");
  AST_PORT_OFF_FLAGS: assert property (s_port_off |->
    tx_empty_flag_ff && tx_idle_flag_ff && rx_idle_flag_ff && !tx_on_eff_ff
    && !rx_on_eff_ff && !break_eff_ff) else $error("flags wrong when off");
  AST_TX_OFF_PIN: assert property (
    !tx_on ##1 !tx_on |=> !serial_out_oe_ff)
    else $error("pin driven with tx off");
  AST_IRQ_RAISE: assert property (
    tx_irq_on && tx_empty_flag_ff && port_on |=> tx_irq_ff)
    else $error("irq missing");
  AST_IRQ_MASK: assert property ((!tx_irq_on || !port_on) |=> !tx_irq_ff)
    else $error("irq while masked");
  AST_CLR_IDLE: assert property (s_rd_wr |=> !tx_idle_flag_ff)
    else $error("idle not cleared by write");
  AST_START: assert property (
    s_rd_wr ##0 tx_idle_flag_ff |-> ##[2:4] $fell(serial_out_pin_ff))
    else $error("no start bit after idle write");
  AST_HOLD: assert property (
    $fell(tx_empty_flag_ff) && port_on |-> !tx_idle_flag_ff)
    else $error("buffer filled while idle");
  AST_END_HIGH: assert property (
    $rose(tx_idle_flag_ff) && $past(port_on) && port_on && $past(tx_on) &&
    tx_on |-> serial_out_pin_ff) else $error("line low at frame end");
endmodule // uft_checker

bind uft_tx_top uft_checker u_chk (.clk, .arst_n, .port_on, .tx_on,
  .tx_irq_on, .status_rd, .data_wr, .tx_empty_flag_ff, .tx_idle_flag_ff,
  .rx_idle_flag_ff, .tx_irq_ff, .tx_on_eff_ff, .rx_on_eff_ff, .break_eff_ff,
  .serial_out_pin_ff, .serial_out_oe_ff);
`default_nettype wire

// file: verification/uft_line_rx.sv
/*
  remote serial receiver listening on the transmit line.
  assumes integer bit period d clocks; receive line echoes the driven
  transmit line and otherwise rests on its pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module uft_line_rx #(
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // transmit line from the block
  input wire logic line,
  input wire logic line_oe,
  // bits expected after the start bit
  input wire logic [3:0] nbits,
  // receive line towards the block
  output wire logic serial_in_pin,
  // last whole frame after the start bit, first data bit in bit 0
  output var logic [11:0] frame_bits,
  output var logic [7:0] frame_cnt
);
  // echo while driven, pull-up level when released
  assign serial_in_pin = line_oe ? line : 1'b1;
  initial begin
    frame_bits = 12'hfff;
    frame_cnt = 8'h00;
  end
  // start edge, then one sample per bit near its middle
  always begin : rx_frame
    logic [11:0] bits;
    logic ok;
    @(negedge clk);
    if (arst_n && line_oe && line === 1'b0) begin
      bits = 12'hfff;
      repeat (D / 2) @(negedge clk);
      ok = (line === 1'b0);
      for (int i = 0; i < 12; i++) begin
        if (i < nbits && ok) begin
          repeat (D) @(negedge clk);
          ok = (line_oe === 1'b1); // aborted frame dropped
          bits[i] = line;
        end
      end
      if (ok) begin
        frame_bits = bits;
        frame_cnt = frame_cnt + 8'h01;
      end
    end
  end
endmodule // uft_line_rx
`default_nettype wire

// file: verification/uart_format_and_transmitter_tb.sv
/*
  self-checking bench: formats, buffering, abort, fractional rate.
  assumes the bound checker and a uft_line_rx on the line.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uft_defines.vh"
module uart_format_and_transmitter_tb;
  localparam int DIV = 8;
  // {nine bits, parity on, parity type, two stops}
  localparam logic [4:0] CFG [7] = '{5'h00, 5'h08, 5'h0a, 5'h0c, 5'h0e,
    5'h1b, 5'h10};
  logic clk, arst_n, port_on, tx_on, rx_on, tx_irq_on, break_request;
  logic data_len_sel, parity_on, stop_count_sel, tx_bit9, status_rd, data_wr;
  logic [1:0] parity_type_sel;
  logic [15:0] divisor;
  logic [2:0] frac_adjust;
  logic [7:0] data_buffer;
  logic [3:0] nbits;
  wire serial_in_pin, tx_empty_flag_ff, tx_idle_flag_ff, tx_irq_ff;
  wire serial_out_pin_ff, serial_out_oe_ff, tx_on_eff_ff;
  wire serial_in_sel_ff, serial_in_lvl_ff, rx_idle_flag_ff, rx_avail_flag_ff;
  wire overrun_flag_ff, framing_flag_ff, parity_fault_flag_ff, noise_flag_ff;
  wire [6:0] rxs = {serial_in_sel_ff, rx_idle_flag_ff, rx_avail_flag_ff,
    overrun_flag_ff, framing_flag_ff, parity_fault_flag_ff, noise_flag_ff};
  wire [11:0] frame_bits;
  wire [7:0] frame_cnt;
  wire [3:0] st = {tx_empty_flag_ff, tx_idle_flag_ff, serial_out_oe_ff,
    tx_irq_ff};
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  uft_tx_top dut (.clk, .arst_n, .port_on, .tx_on, .rx_on, .tx_irq_on,
    .break_request, .data_len_sel, .parity_on, .parity_type_sel,
    .stop_count_sel, .tx_bit9, .divisor, .frac_adjust, .status_rd, .data_wr,
    .data_buffer, .tx_empty_flag_ff, .tx_idle_flag_ff, .rx_idle_flag_ff,
    .tx_irq_ff, .tx_on_eff_ff, .rx_on_eff_ff(), .break_eff_ff(),
    .rx_avail_flag_ff, .overrun_flag_ff, .framing_flag_ff,
    .parity_fault_flag_ff, .noise_flag_ff, .serial_in_pin,
    .serial_out_pin_ff, .serial_out_oe_ff, .serial_in_sel_ff,
    .serial_in_lvl_ff);
  uft_line_rx #(.D(DIV)) u_rx (.clk, .arst_n, .line(serial_out_pin_ff),
    .line_oe(serial_out_oe_ff), .nbits, .serial_in_pin, .frame_bits,
    .frame_cnt);

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // cycle ceiling against a hung run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim;
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_val(input logic [11:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h", $time, m, got);
    end
  endtask
  task automatic chk_num(input int got, lo, hi, input string m);
    total_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("MISMATCH %0t %s got %0d", $time, m, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // status access then data write, one cycle each
  task automatic wr(input logic [7:0] d, input logic b9);
    step(1);
    status_rd = 1'b1;
    step(1);
    status_rd = 1'b0;
    data_wr = 1'b1;
    data_buffer = d;
    tx_bit9 = b9;
    step(1);
    data_wr = 1'b0;
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (tx_idle_flag_ff !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic next_frame;
    logic [7:0] m;
    int n;
    m = frame_cnt;
    n = 0;
    while (frame_cnt === m && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  // wire image: data, optional parity, then ones
  function automatic logic [11:0] exp_frame(input logic [7:0] d,
      input logic b9, input logic [4:0] c);
    logic [11:0] f;
    logic p;
    f = {3'h7, c[4] ? b9 : 1'b1, d};
    p = c[4] ? ^{b9, d} : ^d;
    case (c[2:1])
      `UFT_PAR_ODD: p = ~p;
      `UFT_PAR_EVEN: p = p;
      `UFT_PAR_MARK: p = 1'b1;
      default: p = 1'b0;
    endcase
    if (c[3]) f[c[4] ? 9 : 8] = p;
    return f;
  endfunction

  // every format from the table, length and bits
  task automatic t_formats;
    int n, tot;
    logic [7:0] d;
    logic [4:0] c;
    for (int i = 0; i < 7; i++) begin
      c = CFG[i];
      d = 8'h5a + 8'(i * 37);
      step(1);
      {data_len_sel, parity_on, parity_type_sel, stop_count_sel} = c;
      tot = 10 + int'(c[4]) + int'(c[3]) + int'(c[0]);
      nbits = 4'(tot - 1);
      wr(d, i[0]);
      wait_idle(n);
      chk_num(n, tot * DIV - 3, tot * DIV + 5, "frame time");
      chk_val(frame_bits, exp_frame(d, i[0], c), "frame");
    end
  endtask
  // two words back to back, a third refused while the empty flag is low
  task automatic t_b2b;
    logic [7:0] m;
    int n;
    m = frame_cnt;
    nbits = 4'h9;
    {data_len_sel, parity_on, parity_type_sel, stop_count_sel} = 5'h00;
    tx_irq_on = 1'b1;
    wr(8'hc3, 1'b0);
    step(4);
    chk_val({8'h00, st}, 12'h00b, "idle write");
    wr(8'h96, 1'b0);
    wr(8'h0f, 1'b0);
    chk_val({serial_in_lvl_ff, rxs, st}, 12'h602, "word held");
    next_frame;
    chk_val(frame_bits, exp_frame(8'hc3, 1'b0, 5'h00), "first");
    next_frame;
    chk_val(frame_bits, exp_frame(8'h96, 1'b0, 5'h00), "second");
    wait_idle(n);
    step(2);
    chk_val({serial_in_lvl_ff, rxs, st}, 12'he0f, "drained");
    tx_irq_on = 1'b0;
    step(120);
    chk_val({frame_cnt, st}, {m + 8'h02, 4'he}, "refused");
  endtask
  // transmit off and port off in mid-frame
  task automatic t_abort;
    logic [7:0] m;
    break_request = 1'b1;
    wr(8'h00, 1'b0);
    step(30);
    tx_on = 1'b0;
    step(3);
    chk_val({8'h00, st}, 12'h00c, "tx off");
    wr(8'h11, 1'b0);
    tx_on = 1'b1;
    wr(8'h22, 1'b0);
    chk_val({7'h00, serial_out_pin_ff, st}, 12'h002, "early write");
    step(20);
    port_on = 1'b0;
    step(3);
    chk_val({rxs, tx_on_eff_ff, st}, 12'h40c, "port off");
    m = frame_cnt;
    port_on = 1'b1;
    break_request = 1'b0;
    step(200);
    chk_val({4'h0, frame_cnt}, {4'h0, m}, "flushed");
    wr(8'hb4, 1'b0);
    next_frame;
    chk_val(frame_bits, exp_frame(8'hb4, 1'b0, 5'h00), "re-enabled");
  endtask
  // run lengths of 0x55 with fraction 3/8
  task automatic t_frac;
    int n;
    logic lvl;
    wait_idle(n);
    step(1);
    frac_adjust = 3'h3;
    wr(8'h55, 1'b0);
    n = 0;
    while (serial_out_pin_ff !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    lvl = 1'b0;
    for (int k = 0; k < 9; k++) begin
      n = 0;
      while (serial_out_pin_ff === lvl && n < 40) begin
        @(negedge clk);
        n++;
      end
      chk_num(n, DIV + int'(k inside {2, 5, 7}), DIV + int'(k inside {2, 5, 7}),
        "bit time");
      lvl = ~lvl;
    end
    wait_idle(n);
    step(1);
    frac_adjust = 3'h0;
  endtask

  // reset, enable, scenarios
  initial begin
    {port_on, tx_on, rx_on, tx_irq_on, break_request} = 5'h00;
    {data_len_sel, parity_on, parity_type_sel, stop_count_sel} = 5'h00;
    {tx_bit9, status_rd, data_wr} = 3'h0;
    divisor = 16'(DIV);
    frac_adjust = 3'h0;
    data_buffer = 8'h00;
    nbits = 4'h9;
    arst_n = 1'b0;
    step(4);
    arst_n = 1'b1;
    chk_val({rxs, serial_out_pin_ff, st}, 12'h41c, "reset");
    {port_on, tx_on, rx_on} = 3'h7;
    step(2);
    t_formats;
    t_b2b;
    t_abort;
    t_frac;
    end_sim;
  end
endmodule // uart_format_and_transmitter_tb
`default_nettype wire
